/* File: bench/clear_pin_model.sv */
// Model of the external clear pin driver and the debug tool.
`timescale 1ns/100ps
module clear_pin_model (
    input  wire logic       clk,
    input  wire logic [3:0] hold_low,
    output logic            master_n,
    output logic [2:0]      sec_n
);
    // The pins idle high, as a pull-up would leave them, and fall only on request.
    initial {master_n, sec_n} = 4'hF;
    always @(posedge clk) {master_n, sec_n} <= ~hold_low;
endmodule

/* File: bench/reset_cause_capture_props.sv */
// Port-level checks bound onto the reset cause capture block.
`timescale 1ns/100ps
module reset_cause_props (
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic AVS_WAITREQUEST,
    input wire logic MASTER_CLEAR_PIN_N,
    input wire logic DUAL_DEBUG_MODE,
    input wire logic TRAP_CONFLICT_EVENT,
    input wire logic ILLEGAL_ACCESS_EVENT,
    input wire logic CONFIG_MISMATCH_EVENT,
    input wire logic RESET_INSTRUCTION_EVENT,
    input wire logic WATCHDOG_TIMEOUT_EVENT,
    input wire logic BROWNOUT_EVENT,
    input wire logic DEVICE_RESET,
    input wire logic SECONDARY_CORE_RESET,
    input wire logic REGULATOR_KEEPALIVE,
    input wire logic IRQ
);
    logic ev;
    assign ev = TRAP_CONFLICT_EVENT | ILLEGAL_ACCESS_EVENT | CONFIG_MISMATCH_EVENT
        | RESET_INSTRUCTION_EVENT | WATCHDOG_TIMEOUT_EVENT | BROWNOUT_EVENT;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    chk_wait_one: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("no answer one cycle after a request");
    chk_wait_pulse: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    chk_trap_reset: assert property (TRAP_CONFLICT_EVENT |=> DEVICE_RESET)
        else $error("trap conflict did not reset the device");
    chk_instr_reset: assert property (RESET_INSTRUCTION_EVENT |=> DEVICE_RESET)
        else $error("reset instruction did not reset the device");
    chk_post_reset: assert property (
        $fell(SRST) |-> !DEVICE_RESET && !IRQ && !REGULATOR_KEEPALIVE)
        else $error("outputs wrong after power-on reset");
    chk_sec_ignored: assert property (!DUAL_DEBUG_MODE |=> !SECONDARY_CORE_RESET)
        else $error("secondary reset outside dual debug");
    chk_pin_reset: assert property (!MASTER_CLEAR_PIN_N [*7] |-> DEVICE_RESET)
        else $error("device not in reset while clear pin low");
    chk_keep_hold: assert property (!AVS_WRITE |=> $stable(REGULATOR_KEEPALIVE))
        else $error("keep-alive changed without a write");
    chk_reset_cause: assert property (
        $rose(DEVICE_RESET) |-> $past(ev) || !$past(MASTER_CLEAR_PIN_N, 3))
        else $error("device reset without a cause");
    cover property (IRQ);
    cover property (SECONDARY_CORE_RESET);
    cover property ($rose(DEVICE_RESET) && !MASTER_CLEAR_PIN_N);
endmodule
bind reset_cause_capture reset_cause_props chk (.*);

/* File: bench/tb_reset_cause_capture.sv */
// Self-checking testbench of the reset cause capture block.
`timescale 1ns/100ps
module tb_reset_cause_capture;
    import reset_cause_pkg::*;
    logic                REF_CLK = 0, SRST = 1, AVS_READ = 0, AVS_WRITE = 0;
    logic                DUAL_DEBUG_MODE = 0, MASTER_CLEAR_PIN_N, AVS_WAITREQUEST;
    logic                DEVICE_RESET, SECONDARY_CORE_RESET, REGULATOR_KEEPALIVE, IRQ;
    logic [ADDR_W-1:0]   AVS_ADDRESS = '0;
    logic [DATA_W-1:0]   AVS_WRITEDATA = '0, AVS_READDATA, q;
    logic [3:0]          AVS_BYTEENABLE = 4'hF, hold = 4'h0;
    logic [7:0]          ev = 8'h00;
    logic [SEC_PINS-1:0] SECONDARY_CORE_DEBUG_CLEAR_PIN_N;
    logic [31:0]         seed = 32'h5D81;
    int                  mismatches = 0, tests_run = 0, exp_cause, bm;
    int                  pos[8] = '{2, 3, 1, 4, 6, 9, 14, 15};
    reset_cause_capture dut (.*, .TRAP_CONFLICT_EVENT(ev[7]), .ILLEGAL_ACCESS_EVENT(ev[6]),
        .CONFIG_MISMATCH_EVENT(ev[5]), .RESET_INSTRUCTION_EVENT(ev[4]),
        .WATCHDOG_TIMEOUT_EVENT(ev[3]), .BROWNOUT_EVENT(ev[2]), .SLEEP_MODE(ev[1]),
        .IDLE_MODE(ev[0]));
    clear_pin_model pins (.clk(REF_CLK), .hold_low(hold), .master_n(MASTER_CLEAR_PIN_N),
        .sec_n(SECONDARY_CORE_DEBUG_CLEAR_PIN_N));
    always #5 REF_CLK = ~REF_CLK;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask
    // The request stands from just after one rising edge until the rising edge at
    // which waitrequest is sampled low; read data is taken and the request dropped there.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int k;
        k = 0;
        @(posedge REF_CLK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_BYTEENABLE <= be;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge REF_CLK);
            k++;
        end while (AVS_WAITREQUEST !== 1'b0 && k < 20);
        q = AVS_READDATA;
        AVS_READ <= 0;
        AVS_WRITE <= 0;
        if (AVS_WAITREQUEST !== 1'b0) begin
            mismatches++;
            stop_test();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        bus(0, a, 0, 4'hF);
        chk(q, e);
    endtask
    task automatic wait_reset(input logic v);
        int k;
        k = 0;
        do begin
            @(negedge REF_CLK);
            k++;
        end while (DEVICE_RESET !== v && k < 12);
        if (k >= 12) begin
            mismatches++;
            stop_test();
        end
        @(posedge REF_CLK);
    endtask
    initial begin
        repeat (4) @(posedge REF_CLK);
        SRST <= 0;
        rd(OFS_CAUSE, 32'h3);
        rd(OFS_IRQ_STAT, 0);
        rd(OFS_IRQ_MASK, 0);
        rd(4'hC, 0);
        $display("test reset_values done");
        exp_cause = 3;
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            bm = {16'h0, {8{seed[20]}}, {8{seed[16]}}};
            bus(1, OFS_CAUSE, seed | 1, {seed[25:24], seed[20], seed[16]});
            exp_cause = ((exp_cause & ~bm) | ((seed | 1) & bm)) & 16'hC3DF;
            rd(OFS_CAUSE, exp_cause);
            chk(REGULATOR_KEEPALIVE, exp_cause[8]);
        end
        $display("test software_access done");
        bus(1, OFS_CAUSE, 32'h1, 4'hF);
        exp_cause = 1;
        // Flags pile up without clearing, so each earlier flag must survive the later events.
        for (int i = 0; i < 8; i++) begin
            @(posedge REF_CLK);
            ev <= 8'h1 << i;
            @(posedge REF_CLK);
            ev <= 8'h0;
            exp_cause |= 1 << pos[i];
            rd(OFS_CAUSE, exp_cause);
        end
        bus(0, OFS_IRQ_STAT, 0, 4'hF);
        chk(q[15:14], 2'b11);
        chk(IRQ, 0);
        bus(1, OFS_IRQ_MASK, 32'h8000, 4'hF);
        rd(OFS_IRQ_MASK, 32'h8000);
        chk(IRQ, 1);
        bus(1, OFS_IRQ_STAT, 32'h8000, 4'hF);
        rd(OFS_IRQ_MASK, 32'h8000);
        chk(IRQ, 0);
        $display("test events done");
        bus(1, OFS_CAUSE, 32'h1, 4'hF);
        hold <= 4'h7;
        repeat (8) @(posedge REF_CLK);
        DUAL_DEBUG_MODE <= 1;
        @(negedge REF_CLK);
        chk(SECONDARY_CORE_RESET, 0);
        repeat (2) @(posedge REF_CLK);
        @(negedge REF_CLK);
        chk(SECONDARY_CORE_RESET, 1);
        chk(DEVICE_RESET, 0);
        @(posedge REF_CLK);
        hold <= 4'h8;
        DUAL_DEBUG_MODE <= 0;
        wait_reset(1);
        repeat (6) @(posedge REF_CLK);
        hold <= 4'h0;
        wait_reset(0);
        rd(OFS_CAUSE, 32'h81);
        $display("test clear_pins done");
        @(posedge REF_CLK);
        SRST <= 1;
        repeat (3) @(posedge REF_CLK);
        SRST <= 0;
        rd(OFS_CAUSE, 32'h3);
        $display("test second_reset done");
        stop_test();
    end
endmodule

/* File: logic/irq_unit.sv */
// Sticky interrupt status with write-one-to-clear, a mask and one level output.
`timescale 1ns/100ps
module irq_unit
    import reset_cause_pkg::*;
#(
    parameter int W = CAUSE_W
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    input  wire logic         mask_we,
    input  wire logic [W-1:0] mask_wen,
    input  wire logic [W-1:0] mask_data,
    output logic      [W-1:0] status,
    output logic      [W-1:0] mask,
    output logic              irq
);
    typedef struct packed {
        logic [W-1:0] stat;
        logic [W-1:0] msk;
        logic         irq;
    } irq_state_t;

    irq_state_t r;
    irq_state_t next_r;

    always_comb begin
        next_r = r;
        // A set arriving in the cycle of its clear wins.
        next_r.stat = (r.stat & ~clr) | set;
        if (mask_we) begin
            next_r.msk = (r.msk & ~mask_wen) | (mask_data & mask_wen);
        end
        next_r.irq = |(next_r.stat & next_r.msk);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign status = r.stat;
    assign mask   = r.msk;
    assign irq    = r.irq;
endmodule

/* File: logic/pin_sync.sv */
// Three-stage pin synchroniser with a two-stage agreement filter.
`timescale 1ns/100ps
module pin_sync
    import reset_cause_pkg::*;
#(
    parameter int             W         = 1,
    parameter logic [W-1:0]   IDLE_LVL  = '1
) (
    input  wire logic         clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } sync_t;

    sync_t r;
    sync_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = pin;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // A change is accepted only once the second and third stages agree.
        next_r.lvl = (~(r.s2 ^ r.s3) & r.s2) | ((r.s2 ^ r.s3) & r.lvl);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            r <= {IDLE_LVL, IDLE_LVL, IDLE_LVL, IDLE_LVL};
        end else begin
            r <= next_r;
        end
    end

    assign level = r.lvl;
endmodule

/* File: logic/reset_cause_capture.sv */
// Reset cause capture with Avalon-MM register access and a cause interrupt.
`timescale 1ns/100ps
module reset_cause_capture
    import reset_cause_pkg::*;
(
    input  wire logic                REF_CLK,
    input  wire logic                SRST,
    // Avalon-MM slave.
    input  wire logic [ADDR_W-1:0]   AVS_ADDRESS,
    input  wire logic                AVS_READ,
    input  wire logic                AVS_WRITE,
    input  wire logic [DATA_W-1:0]   AVS_WRITEDATA,
    input  wire logic [3:0]          AVS_BYTEENABLE,
    output logic      [DATA_W-1:0]   AVS_READDATA,
    output logic                     AVS_WAITREQUEST,
    // Pins from outside the clock domain.
    input  wire logic                MASTER_CLEAR_PIN_N,
    input  wire logic [SEC_PINS-1:0] SECONDARY_CORE_DEBUG_CLEAR_PIN_N,
    // Event strobes and levels from on-chip logic on the same clock.
    input  wire logic                DUAL_DEBUG_MODE,
    input  wire logic                TRAP_CONFLICT_EVENT,
    input  wire logic                ILLEGAL_ACCESS_EVENT,
    input  wire logic                CONFIG_MISMATCH_EVENT,
    input  wire logic                RESET_INSTRUCTION_EVENT,
    input  wire logic                WATCHDOG_TIMEOUT_EVENT,
    input  wire logic                SLEEP_MODE,
    input  wire logic                IDLE_MODE,
    input  wire logic                BROWNOUT_EVENT,
    // Results.
    output logic                     DEVICE_RESET,
    output logic                     SECONDARY_CORE_RESET,
    output logic                     REGULATOR_KEEPALIVE,
    output logic                     IRQ
);

    typedef struct packed {
        logic [CAUSE_W-1:0] cause;
        logic [DATA_W-1:0]  rdata;
        logic               waitreq;
        logic               pin_low_prev;
        logic               sleep_prev;
        logic               idle_prev;
        logic               dev_rst;
        logic               sec_rst;
    } top_state_t;

    top_state_t r;
    top_state_t next_r;

    logic                master_clear_pin_level;
    logic [SEC_PINS-1:0] sec_level;
    logic [CAUSE_W-1:0]  irq_status;
    logic [CAUSE_W-1:0]  irq_mask;
    logic                irq_level;

    logic [CAUSE_W-1:0]  hw_set;
    logic [CAUSE_W-1:0]  lane_mask;
    logic                accept;
    logic                wr_take;
    logic                wr_cause;
    logic                wr_irq_stat;
    logic                wr_irq_mask;
    logic [CAUSE_W-1:0]  irq_clr;
    logic                pin_low;
    logic                any_sec_low;
    logic                hw_reset_req;

    pin_sync #(
        .W        (1),
        .IDLE_LVL (1'b1)
    ) u_master_clear_pin_sync (
        .clk   (REF_CLK),
        .srst  (SRST),
        .pin   (MASTER_CLEAR_PIN_N),
        .level (master_clear_pin_level)
    );

    pin_sync #(
        .W        (SEC_PINS),
        .IDLE_LVL ({SEC_PINS{1'b1}})
    ) u_sec_sync (
        .clk   (REF_CLK),
        .srst  (SRST),
        .pin   (SECONDARY_CORE_DEBUG_CLEAR_PIN_N),
        .level (sec_level)
    );

    // Hardware reset and wake events, one bit per cause flag position.
    always_comb begin
        pin_low     = ~master_clear_pin_level; // RQ1
        any_sec_low = |(~sec_level);
        hw_set      = '0;
        hw_set[BIT_TRAP]     = TRAP_CONFLICT_EVENT; // RQ3
        hw_set[BIT_ILLEGAL]  = ILLEGAL_ACCESS_EVENT; // RQ4
        hw_set[BIT_CFG]      = CONFIG_MISMATCH_EVENT; // RQ14
        // Only the falling edge of the filtered pin marks a new pin reset.
        hw_set[BIT_PIN]      = pin_low & ~r.pin_low_prev; // RQ6
        hw_set[BIT_INSTR]    = RESET_INSTRUCTION_EVENT; // RQ7
        hw_set[BIT_WDT]      = WATCHDOG_TIMEOUT_EVENT; // RQ8
        hw_set[BIT_SLEEP]    = SLEEP_MODE & ~r.sleep_prev; // RQ9
        hw_set[BIT_IDLE]     = IDLE_MODE & ~r.idle_prev; // RQ10
        hw_set[BIT_BROWNOUT] = BROWNOUT_EVENT;
        hw_reset_req = TRAP_CONFLICT_EVENT | ILLEGAL_ACCESS_EVENT | CONFIG_MISMATCH_EVENT
                     | RESET_INSTRUCTION_EVENT | WATCHDOG_TIMEOUT_EVENT | BROWNOUT_EVENT;
    end

    // Bus decode: a request is accepted one edge after it is raised, and
    // the write takes effect at the edge where waitrequest is seen low.
    always_comb begin
        accept    = (AVS_READ | AVS_WRITE) & r.waitreq;
        wr_take   = AVS_WRITE & ~r.waitreq;
        lane_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
        wr_cause    = wr_take & (AVS_ADDRESS == OFS_CAUSE);
        wr_irq_stat = wr_take & (AVS_ADDRESS == OFS_IRQ_STAT);
        wr_irq_mask = wr_take & (AVS_ADDRESS == OFS_IRQ_MASK);
        irq_clr = '0;
        if (wr_irq_stat) begin
            irq_clr = AVS_WRITEDATA[CAUSE_W-1:0] & lane_mask;
        end
    end

    irq_unit #(
        .W (CAUSE_W)
    ) u_irq (
        .clk       (REF_CLK),
        .srst      (SRST),
        .set       (hw_set),
        .clr       (irq_clr),
        .mask_we   (wr_irq_mask),
        .mask_wen  (lane_mask),
        .mask_data (AVS_WRITEDATA[CAUSE_W-1:0]),
        .status    (irq_status),
        .mask      (irq_mask),
        .irq       (irq_level)
    );

    always_comb begin
        next_r = r;
        next_r.pin_low_prev = pin_low;
        next_r.sleep_prev   = SLEEP_MODE;
        next_r.idle_prev    = IDLE_MODE;

        // Software writes touch only implemented bits; unimplemented ones stay zero.
        if (wr_cause) begin
            next_r.cause = (r.cause & ~(lane_mask & CAUSE_WRITABLE))
                         | (AVS_WRITEDATA[CAUSE_W-1:0] & lane_mask & CAUSE_WRITABLE); // RQ12 RQ14
        end
        // Hardware sets override a clear in the same cycle, and nothing but
        // software and SRST clear a flag, so flags survive resets of other kinds.
        next_r.cause = next_r.cause | hw_set; // RQ13

        // The device reset comes only from the master clear pin and hardware reset events; a
        // software write to the cause register is deliberately not a source.
        next_r.dev_rst = pin_low | hw_reset_req; // RQ1 RQ12
        next_r.sec_rst = DUAL_DEBUG_MODE & any_sec_low; // RQ2

        if (accept) begin
            next_r.waitreq = 1'b0;
            next_r.rdata   = '0;
            unique case (AVS_ADDRESS)
                OFS_CAUSE: begin
                    next_r.rdata[CAUSE_W-1:0] = r.cause & CAUSE_WRITABLE; // RQ14
                end
                OFS_IRQ_STAT: begin
                    next_r.rdata[CAUSE_W-1:0] = irq_status;
                end
                OFS_IRQ_MASK: begin
                    next_r.rdata[CAUSE_W-1:0] = irq_mask;
                end
                default: begin
                    next_r.rdata = '0;
                end
            endcase
        end else begin
            next_r.waitreq = 1'b1;
        end
    end

    // SRST is treated as the power-on reset of this block.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            r.cause        <= CAUSE_RESET; // RQ11
            r.rdata        <= '0;
            r.waitreq      <= 1'b1;
            r.pin_low_prev <= 1'b0;
            r.sleep_prev   <= 1'b0;
            r.idle_prev    <= 1'b0;
            r.dev_rst      <= 1'b0;
            r.sec_rst      <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    assign AVS_READDATA         = r.rdata;
    assign AVS_WAITREQUEST      = r.waitreq;
    assign DEVICE_RESET         = r.dev_rst;
    assign SECONDARY_CORE_RESET = r.sec_rst;
    assign REGULATOR_KEEPALIVE  = r.cause[BIT_KEEPALIVE]; // RQ5
    assign IRQ                  = irq_level;
endmodule

/* File: logic/reset_cause_pkg.sv */
// Constants and register layout shared by the reset cause capture logic.
// Behaviour
// [RQ1] The master clear pin is an active-low reset input and holds the device in reset while low.
// [RQ2] Secondary-core clear pins reset the secondary core only in dual debug mode.
// [RQ3] A trap conflict reset sets the trap conflict flag at bit 15.
// [RQ4] An illegal opcode, address mode or uninitialised pointer reset sets bit 14.
// [RQ5] Keep-alive bit 8 keeps the regulator active in sleep when one, standby when zero.
// [RQ6] A master clear pin reset sets the pin reset flag at bit 7, nothing else sets it; in the code a software write to bit 7 also sets it.
// [RQ7] Executing the reset instruction sets the instruction reset flag at bit 6.
// [RQ8] A watchdog time-out sets bit 4, which reads zero while no time-out happened.
// [RQ9] Having been in sleep mode sets bit 3, otherwise it stays zero.
// [RQ10] Having been in idle mode sets bit 2, otherwise it stays zero.
// [RQ11] After power-on reset bits 1 and 0 read one and every other implemented bit zero.
// [RQ12] Software may set or clear every flag, and a software set never resets the device.
// [RQ13] Flags are sticky across later resets of other kinds until software clears them.
// [RQ14] Bits 13 to 10 and 5 read zero and ignore writes; bit 9 flags a configuration mismatch.
package reset_cause_pkg;

    localparam int CAUSE_W = 16;
    localparam int DATA_W  = 32;
    localparam int ADDR_W  = 4;

    localparam int BIT_TRAP      = 15;
    localparam int BIT_ILLEGAL   = 14;
    localparam int BIT_CFG       = 9;
    localparam int BIT_KEEPALIVE = 8;
    localparam int BIT_PIN       = 7;
    localparam int BIT_INSTR     = 6;
    localparam int BIT_WDT       = 4;
    localparam int BIT_SLEEP     = 3;
    localparam int BIT_IDLE      = 2;
    localparam int BIT_BROWNOUT  = 1;
    localparam int BIT_POWERON   = 0;

    localparam logic [CAUSE_W-1:0] CAUSE_RESET    = 16'h0003;
    localparam logic [CAUSE_W-1:0] CAUSE_WRITABLE = 16'hC3DF;

    localparam logic [ADDR_W-1:0] OFS_CAUSE    = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;

    localparam int SEC_PINS = 3;

endpackage
